// ==== bench/adc_trigger_window_align_ctrl_bench.sv ====
// bench for the adc conversion control block
// assumes: axi4-lite master tasks here, converter model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

module adc_trigger_window_align_ctrl_bench;
    localparam int LAT = 5;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, match;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv, cur;
    logic [2:0]  ev;
    logic [9:0]  code, conv_code;
    logic [15:0] exp;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        conv_start, conv_done, window_match, irq;
    int          starts, dones, base, bad_count, samples_checked, cycles;

    adc_trigger_window_align_ctrl uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .timer3_overflow(ev[0]), .timer2_overflow(ev[2]),
        .external_convert_start_pin(ev[1]),
        .conv_start(conv_start), .conv_done(conv_done),
        .conv_code(conv_code), .window_match(window_match), .irq(irq));

    conv_model #(.RES_W(10), .LAT(LAT)) cm (
        .aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .code_in(code), .match_in(match), .conv_done(conv_done),
        .conv_code(conv_code), .window_match(window_match));

    // ------------------------------------------------------------------
    // clock, event counts and hang guard
    // ------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // counting here keeps the scenarios free of pulse timing
    always @(posedge aclk) begin
        cycles++;
        if (conv_start === 1'b1) starts++;
        if (conv_done === 1'b1) dones++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------------
    // bready stays high, so the response is taken where bvalid is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv  = rdata;
        rsp = rresp;
    endtask : rd

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk

    // source 0 is the software busy write, 1..3 drive ev held 4 cycles
    task automatic fire(input int s);
        int n;
        if (s == 0) wr(`ADC_OFF_CTRL, cur | 32'h10);
        else begin
            ev[s-1] <= 1'b1;
            repeat (4) @(posedge aclk);
            ev[s-1] <= 1'b0;
        end
        repeat (2) @(posedge aclk);
        n = 0;
        while (dones != starts && n < 50) begin
            @(posedge aclk);
            n++;
        end
        // a conversion that never answers is a fault, not a wait
        if (dones != starts) begin
            $display("ERROR conv done expected %0d seen %0d", starts, dones);
            bad_count++;
        end
    endtask : fire

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, match} = 4'h0;
        {awaddr, araddr, ev, code} = 29'h0;
        {wdata, cur} = 64'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ADC_OFF_CTRL);
        chk("ctrl reset", 32'h0, rv);
        rd(`ADC_OFF_MASK);
        chk("mask reset", 32'h0, rv);
        // each mode: foreign sources must not start, its own starts once
        for (int m = 0; m < 4; m++) begin
            cur = 32'((m << 2) | (m & 1));
            code <= 10'h2a5 ^ 10'(m);
            match <= (m == 3);
            wr(`ADC_OFF_CTRL, cur);
            base = starts;
            for (int s = 0; s < 4; s++) if (s != m) fire(s);
            chk("stray start", 0, starts - base);
            fire(m);
            chk("start count", 1, starts - base);
            exp = (m & 1) ? {code, 6'h00} : {6'h00, code};
            rd(`ADC_OFF_RESULT);
            chk("result", {16'h0, exp}, rv);
        end
        rd(`ADC_OFF_CTRL);
        chk("win set", 32'h0f, rv);
        // no-match conversion while software keeps the flag
        match <= 1'b0;
        cur = 32'h0f;
        wr(`ADC_OFF_CTRL, cur);
        fire(3);
        rd(`ADC_OFF_CTRL);
        chk("win kept", 32'h0f, rv);
        wr(`ADC_OFF_CTRL, 32'h0d);
        rd(`ADC_OFF_CTRL);
        chk("win cleared", 32'h0d, rv);
        // interrupt: masked, unmasked, cleared
        rd(`ADC_OFF_STATUS);
        chk("status", 32'h3, rv);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`ADC_OFF_MASK, 32'h3);
        rd(`ADC_OFF_MASK);
        chk("mask", 32'h3, rv);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(`ADC_OFF_STATUS, 32'h3);
        rd(`ADC_OFF_STATUS);
        chk("status clr", 32'h0, rv);
        chk("irq off", 32'h0, {31'h0, irq});
        // unmapped place answers with an error and reads zero
        rd(8'h10);
        chk("rd resp", {30'h0, `ADC_RESP_SLVERR}, {30'h0, rsp});
        chk("rd data", 32'h0, rv);
        wr(8'h10, 32'hffffffff);
        chk("wr resp", {30'h0, `ADC_RESP_SLVERR}, {30'h0, rsp});
        rd(`ADC_OFF_CTRL);
        chk("wr no effect", 32'h0d, rv);
        wrap_up();
    end
endmodule : adc_trigger_window_align_ctrl_bench
`default_nettype wire

// ==== bench/conv_model.sv ====
// converter stand-in: answers each conv_start with one conv_done pulse
// assumes: bench holds code_in and match_in steady around the answer
`timescale 1ns/1ps
`default_nettype none

module conv_model #(
    parameter int RES_W = 10,
    parameter int LAT   = 5
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             conv_start,
    input  wire logic [RES_W-1:0] code_in,
    input  wire logic             match_in,
    output logic                  conv_done,
    output logic      [RES_W-1:0] conv_code,
    output logic                  window_match
);
    logic [7:0] cnt;

    // latency counter, restarted by every start pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt       <= 8'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                cnt <= 8'(LAT);
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                conv_done <= (cnt == 8'h01);
            end
        end
    end

    // outside the answer cycle the lines show the inverse, never stale data
    assign conv_code    = conv_done ? code_in : ~code_in;
    assign window_match = conv_done ? match_in : ~match_in;
endmodule : conv_model
`default_nettype wire

// ==== common/adc_ctrl_defines.svh ====
// register offsets, field positions and reset values of the adc control
// assumes: included by bare name from package and rtl files
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADC_OFF_CTRL     8'h00
`define ADC_OFF_RESULT   8'h04
`define ADC_OFF_STATUS   8'h08
`define ADC_OFF_MASK     8'h0c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define ADC_CTRL_ALIGN_BIT   0
`define ADC_CTRL_WIN_BIT     1
`define ADC_CTRL_TRIG_LSB    2
`define ADC_CTRL_TRIG_MSB    3
`define ADC_CTRL_BUSY_BIT    4

// ----------------------------------------------------------------------
// interrupt status fields and reset values
// ----------------------------------------------------------------------
`define ADC_INT_DONE_BIT     0
`define ADC_INT_WIN_BIT      1
`define ADC_RST_TRIG         2'h0
`define ADC_RST_MASK         2'h0
`define ADC_RESP_OKAY        2'h0
`define ADC_RESP_SLVERR      2'h2

`endif

// ==== common/adc_ctrl_pkg.sv ====
// types shared by the adc control block and its helpers
// assumes: the defines header is on the include path
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;
    // start trigger sources
    typedef enum logic [1:0] {
        TRIG_SW    = 2'h0,
        TRIG_TMR3  = 2'h1,
        TRIG_PIN   = 2'h2,
        TRIG_TMR2  = 2'h3
    } trig_sel_e;

    // register identities after decode
    typedef enum logic [4:0] {
        REG_CTRL   = 5'h01,
        REG_RESULT = 5'h02,
        REG_STATUS = 5'h04,
        REG_MASK   = 5'h08,
        REG_NONE   = 5'h10
    } reg_id_e;

    // whole state of the control block
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_full;
        logic        w_full;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        align;
        logic        win_flag;
        trig_sel_e   trig_sel;
        logic        busy;
        logic        conv_start;
        logic [15:0] result;
        logic [1:0]  int_status;
        logic [1:0]  int_mask;
        logic        irq;
    } ctrl_state_s;
endpackage : adc_ctrl_pkg

// ==== rtl/adc_trigger_window_align_ctrl.sv ====
// adc conversion control: trigger select, window flag, justification,
// axi4-lite register slave and one level interrupt
// assumes: timer overflow and pin inputs synchronous to aclk; converter
// answers each conv_start with one conv_done pulse carrying its code
//
// Behaviour
// - mode 00: each software write of one to busy bit starts a conversion; code ignores such a write while busy is set
// - mode 01: every timer 3 overflow starts one conversion; code drops an overflow that comes while busy is set
// - mode 10: every rising edge of convert-start pin starts a conversion; code drops an edge that comes while busy is set
// - mode 11: every timer 2 overflow starts one conversion; code drops an overflow that comes while busy is set
// - window flag bit 1 set when a result matches the window
// - window flag stays set until software writes it back to zero
// - alignment bit 0 clear: result right justified in high and low bytes
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

module adc_trigger_window_align_ctrl #(
    parameter int RES_W = 10
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // trigger sources
    input  wire logic             timer3_overflow,
    input  wire logic             timer2_overflow,
    input  wire logic             external_convert_start_pin,
    // converter side
    output logic                  conv_start,
    input  wire logic             conv_done,
    input  wire logic [RES_W-1:0] conv_code,
    input  wire logic             window_match,
    // interrupt
    output logic                  irq
);
    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // shared by write and read paths; only whole aligned words map
    function automatic adc_ctrl_pkg::reg_id_e decode(input logic [7:0] a);
        if (a == `ADC_OFF_CTRL) begin
            return adc_ctrl_pkg::REG_CTRL;
        end else if (a == `ADC_OFF_RESULT) begin
            return adc_ctrl_pkg::REG_RESULT;
        end else if (a == `ADC_OFF_STATUS) begin
            return adc_ctrl_pkg::REG_STATUS;
        end else if (a == `ADC_OFF_MASK) begin
            return adc_ctrl_pkg::REG_MASK;
        end else begin
            return adc_ctrl_pkg::REG_NONE;
        end
    endfunction : decode

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    adc_ctrl_pkg::ctrl_state_s st;
    adc_ctrl_pkg::ctrl_state_s next_st;
    logic [2:0]                rises;
    logic [15:0]               aligned;
    logic                      do_write;
    logic                      wr_ctrl;
    logic                      wr_status;
    logic                      wr_mask;
    logic                      trig_hit;
    logic                      win_set;
    adc_ctrl_pkg::reg_id_e     wr_id;
    adc_ctrl_pkg::reg_id_e     rd_id;

    // lanes: 0 timer 3, 1 pin, 2 timer 2
    rise_detect #(
        .WIDTH    (3)
    ) u_rise (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in ({timer2_overflow, external_convert_start_pin,
                    timer3_overflow}),
        .rise     (rises)
    );

    // justification is taken from the bit in force at conv_done
    result_align #(
        .RES_W   (RES_W)
    ) u_align (
        .raw     (conv_code),
        .left    (st.align),
        .aligned (aligned)
    );

    // ------------------------------------------------------------------
    // write strobes and trigger selection
    // ------------------------------------------------------------------
    assign do_write  = st.aw_full && st.w_full && !st.bvalid;
    assign wr_id     = decode(st.awaddr);
    assign rd_id     = decode(s_axi_araddr);
    // only lane 0 holds live bits, so only its strobe matters
    assign wr_ctrl   = do_write && st.wstrb[0] &&
                       (wr_id == adc_ctrl_pkg::REG_CTRL);
    assign wr_status = do_write && st.wstrb[0] &&
                       (wr_id == adc_ctrl_pkg::REG_STATUS);
    assign wr_mask   = do_write && st.wstrb[0] &&
                       (wr_id == adc_ctrl_pkg::REG_MASK);
    assign win_set   = conv_done && window_match;

    // a trigger is dropped while a conversion is already running
    always_comb begin
        case (st.trig_sel)
            adc_ctrl_pkg::TRIG_SW: begin
                trig_hit = wr_ctrl &&
                           st.wdata[`ADC_CTRL_BUSY_BIT];
            end
            adc_ctrl_pkg::TRIG_TMR3: begin
                trig_hit = rises[0];
            end
            adc_ctrl_pkg::TRIG_PIN: begin
                trig_hit = rises[1];
            end
            default: begin
                trig_hit = rises[2];
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // write address and data captured independently
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (do_write) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = (wr_id == adc_ctrl_pkg::REG_NONE) ?
                              `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
        end
        next_st.awready = !next_st.aw_full && !next_st.bvalid;
        next_st.wready  = !next_st.w_full && !next_st.bvalid;

        // read: one outstanding, data registered with rvalid
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = `ADC_RESP_OKAY;
            next_st.rdata   = 32'h0000_0000;
            if (rd_id == adc_ctrl_pkg::REG_CTRL) begin
                next_st.rdata[`ADC_CTRL_ALIGN_BIT] = st.align;
                next_st.rdata[`ADC_CTRL_WIN_BIT]   = st.win_flag;
                next_st.rdata[`ADC_CTRL_TRIG_MSB:`ADC_CTRL_TRIG_LSB] =
                    st.trig_sel;
                next_st.rdata[`ADC_CTRL_BUSY_BIT]  = st.busy;
            end else if (rd_id == adc_ctrl_pkg::REG_RESULT) begin
                next_st.rdata[15:0] = st.result;
            end else if (rd_id == adc_ctrl_pkg::REG_STATUS) begin
                next_st.rdata[1:0] = st.int_status;
            end else if (rd_id == adc_ctrl_pkg::REG_MASK) begin
                next_st.rdata[1:0] = st.int_mask;
            end else begin
                next_st.rresp = `ADC_RESP_SLVERR;
            end
        end

        // control fields; busy is not writable apart from the start
        if (wr_ctrl) begin
            next_st.align    = st.wdata[`ADC_CTRL_ALIGN_BIT];
            next_st.trig_sel = adc_ctrl_pkg::trig_sel_e'(
                st.wdata[`ADC_CTRL_TRIG_MSB:`ADC_CTRL_TRIG_LSB]);
        end
        // software may only clear the flag; a match this cycle wins
        if (wr_ctrl && !st.wdata[`ADC_CTRL_WIN_BIT]) begin
            next_st.win_flag = 1'b0;
        end
        if (win_set) begin
            next_st.win_flag = 1'b1;
        end

        // conversion lifecycle: done clears, a fresh start sets
        next_st.conv_start = 1'b0;
        if (conv_done) begin
            next_st.busy   = 1'b0;
            next_st.result = aligned;
        end
        if (trig_hit && !st.busy) begin
            next_st.busy       = 1'b1;
            next_st.conv_start = 1'b1;
        end

        // sticky interrupt status, write one to clear, set wins
        if (wr_status) begin
            next_st.int_status = st.int_status & ~st.wdata[1:0];
        end
        if (conv_done) begin
            next_st.int_status[`ADC_INT_DONE_BIT] = 1'b1;
        end
        if (win_set) begin
            next_st.int_status[`ADC_INT_WIN_BIT] = 1'b1;
        end
        if (wr_mask) begin
            next_st.int_mask = st.wdata[1:0];
        end
        next_st.irq = |(next_st.int_status & next_st.int_mask);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
            st.trig_sel <= adc_ctrl_pkg::trig_sel_e'(`ADC_RST_TRIG);
            st.int_mask <= `ADC_RST_MASK;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = st.rdata;
    assign conv_start    = st.conv_start;
    assign irq           = st.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sw_start_a: assert property (
        (st.trig_sel == adc_ctrl_pkg::TRIG_SW && wr_ctrl &&
         st.wdata[`ADC_CTRL_BUSY_BIT] && !st.busy)
        |=> (conv_start && st.busy))
        else $error("software start did not begin a conversion");

    tmr3_start_a: assert property (
        (st.trig_sel == adc_ctrl_pkg::TRIG_TMR3 && $rose(timer3_overflow)
         && !st.busy) |=> conv_start)
        else $error("timer 3 overflow did not start a conversion");

    pin_start_a: assert property (
        (st.trig_sel == adc_ctrl_pkg::TRIG_PIN &&
         $rose(external_convert_start_pin) && !st.busy) |=> conv_start)
        else $error("pin rising edge did not start a conversion");

    tmr2_start_a: assert property (
        (st.trig_sel == adc_ctrl_pkg::TRIG_TMR2 && $rose(timer2_overflow)
         && !st.busy) |=> conv_start)
        else $error("timer 2 overflow did not start a conversion");

    start_cause_a: assert property (
        conv_start |-> ($past(!st.busy) && $past(trig_hit)))
        else $error("conversion started without a selected trigger");

    // flag and sticky status bit must both follow a match
    win_set_a: assert property (
        win_set |=> (st.win_flag && st.int_status[`ADC_INT_WIN_BIT]))
        else $error("window match did not set the flag");

    win_clear_a: assert property (
        (wr_ctrl && !st.wdata[`ADC_CTRL_WIN_BIT] && !win_set)
        |=> !st.win_flag)
        else $error("software clear left the window flag set");

    win_hold_a: assert property (
        (st.win_flag && !(wr_ctrl && !st.wdata[`ADC_CTRL_WIN_BIT]))
        |=> st.win_flag)
        else $error("window flag dropped without software clear");

    right_just_a: assert property (
        (conv_done && !st.align) |=>
        st.result == {{(16-RES_W){1'b0}}, $past(conv_code)})
        else $error("right justified result wrong");

    left_just_a: assert property (
        (conv_done && st.align) |=>
        st.result == {$past(conv_code), {(16-RES_W){1'b0}}})
        else $error("left justified result wrong");

    bresp_hold_a: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before bready");

    // status bit only leaves by a write of one from software
    status_hold_a: assert property (
        (st.int_status[`ADC_INT_WIN_BIT] &&
         !(wr_status && st.wdata[`ADC_INT_WIN_BIT]))
        |=> st.int_status[`ADC_INT_WIN_BIT])
        else $error("window status bit dropped without a clear");

    cover_pin_c:  cover property (
        st.trig_sel == adc_ctrl_pkg::TRIG_PIN ##1 conv_start);
    cover_tmr2_c: cover property (
        st.trig_sel == adc_ctrl_pkg::TRIG_TMR2 ##1 conv_start);
    cover_win_c:  cover property (win_set ##1 st.win_flag ##[1:20] !st.win_flag);
    cover_left_c: cover property (conv_done && st.align);
    cover_sw_c:   cover property (
        st.trig_sel == adc_ctrl_pkg::TRIG_SW ##1 conv_start);
endmodule : adc_trigger_window_align_ctrl

`default_nettype wire

// ==== rtl/result_align.sv ====
// justifies a raw converter code into a 16-bit high:low result pair
// assumes: raw code is valid in the cycle it is used; no state
`timescale 1ns/1ps
`default_nettype none

module result_align #(
    parameter int RES_W = 10
) (
    input  wire logic [RES_W-1:0] raw,
    input  wire logic             left,
    output logic      [15:0]      aligned
);
    localparam int PAD = 16 - RES_W;

    // left fills low bits with zeros, right fills high bits with zeros
    always_comb begin
        if (left) begin
            aligned = {raw, {PAD{1'b0}}};
        end else begin
            aligned = {{PAD{1'b0}}, raw};
        end
    end
endmodule : result_align

`default_nettype wire

// ==== rtl/rise_detect.sv ====
// rising edge detector over a vector of event inputs
// assumes: inputs already synchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module rise_detect #(
    parameter int WIDTH = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } edge_state_s;

    edge_state_s st;
    edge_state_s next_st;

    // previous sample; reset low so a high input at release counts once
    always_comb begin
        next_st.prev = level_in;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // one pulse per low to high step, per lane
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            assign rise[i] = level_in[i] & ~st.prev[i];
        end
    endgenerate
endmodule : rise_detect

`default_nettype wire
